// ---- hw/usp_top.sv ----
/*
 * Serial port with mode control, multiprocessor filtering, ninth bit,
 * framing error and completion flags, behind an APB slave.
 * Assumes a zero-wait APB master on core_clk and an optional external
 * timer overflow pulse on the same clock.
 */
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "usp_defs.svh"
module usp_top
    import usp_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timerOvf,
    output logic             txd,
    input  wire logic        rxdIn,
    output logic             rxdOut,
    output logic             rxdOeN,
    output logic             irq
);
    localparam usp_state_s RST_STATE = '{
        scon: `USP_CTRL_RST, bcon: `USP_BAUD_RST, reload: `USP_RELOAD_RST,
        irqSt: `USP_IRQ_RST, irqMask: `USP_IRQ_RST,
        txSt: TX_IDLE, rxSt: RX_IDLE,
        txLine: 1'b1, m0Clk: 1'b1, txd: 1'b1, rxdOut: 1'b1, rxdOeN: 1'b1,
        rxPrev: 1'b1, default: '0};

    usp_state_s q;
    usp_state_s d;
    logic       rxdSync;
    logic [1:0] mode;
    logic       fes;
    logic [7:0] view;
    logic       setup;
    logic       wr;
    logic [7:0] wv;
    logic [7:0] wm;
    logic [2:0] ev;
    logic       m0Half;
    logic       ovfSrc;
    logic       tick13;
    logic       tick;
    logic       startTx;
    logic       accept;
    logic       sm2;
    logic       ren;

    usp_brg_if brgIf ();

    usp_sync uSync
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .din      (rxdIn),
        .dout     (rxdSync)
    );

    usp_brg uBrg
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .bus      (brgIf.gen)
    );

    assign brgIf.reload = q.reload;
    assign brgIf.speed  = q.bcon[`USP_BAUD_SPD];
    assign brgIf.run    = q.bcon[`USP_BAUD_RUN];

    function automatic logic isMapped(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a[7:5] == 3'b000);
    endfunction : isMapped

    function automatic logic [7:0] applyBits(input logic [7:0] old,
                                             input logic [7:0] val,
                                             input logic [7:0] mask);
        return (old & ~mask) | (val & mask);
    endfunction : applyBits

    always_comb
    begin
        d = q;
        ev = 3'h0;
        accept = 1'b0;
        mode = {q.scon[`USP_CTRL_SM0], q.scon[`USP_CTRL_SM1]};
        fes = q.bcon[`USP_BAUD_FES];
        view = {fes ? q.fe : q.scon[`USP_CTRL_SM0], q.scon[6:0]};
        sm2 = q.scon[`USP_CTRL_SM2];
        ren = q.scon[`USP_CTRL_REN];
        setup = psel & ~penable;
        wr = psel & penable & pwrite;

        // Bit timing: mode 0 uses half-bit ticks, the others 16 per bit.
        d.divCnt = (q.divCnt == `USP_M0_HALF_DIV) ? 2'd0 : q.divCnt + 2'd1;
        m0Half = q.bcon[`USP_BAUD_SRC] ? brgIf.ovf
                                       : (q.divCnt == `USP_M0_HALF_DIV);
        ovfSrc = q.bcon[`USP_BAUD_SEL] ? brgIf.ovf : timerOvf;
        if (ovfSrc)
            d.ovfHalf = ~q.ovfHalf;
        d.m2Tog = ~q.m2Tog;
        tick13 = ovfSrc & (q.bcon[`USP_BAUD_DBL] | q.ovfHalf);
        tick = (mode == `USP_MODE2) ? (q.bcon[`USP_BAUD_DBL] | q.m2Tog)
                                    : tick13;

        // Software writes land first so that hardware events win below.
        wv = pwdata[7:0];
        wm = 8'h00;
        if (wr)
        begin
            case (paddr)
                `USP_OFF_CTRL:     wm = 8'hff;
                `USP_OFF_CTRL_SET:
                begin
                    wm = pwdata[7:0];
                    wv = 8'hff;
                end
                `USP_OFF_CTRL_CLR:
                begin
                    wm = pwdata[7:0];
                    wv = 8'h00;
                end
                `USP_OFF_BAUD:     d.bcon = pwdata[5:0];
                `USP_OFF_RELOAD:   d.reload = pwdata[7:0];
                `USP_OFF_IRQ_ST:   d.irqSt = q.irqSt & ~pwdata[2:0];
                `USP_OFF_IRQ_MASK: d.irqMask = pwdata[2:0];
                default:           ;
            endcase
        end
        d.scon = applyBits(q.scon, wv, wm & {~fes, 7'h7f});
        if (fes & wm[7] & ~wv[7])
            d.fe = 1'b0;
        startTx = wr & (paddr == `USP_OFF_BUF) & (q.txSt == TX_IDLE)
                  & (q.rxSt != RX_SHIFT);

        unique case (q.txSt)
            TX_IDLE:
            begin
                if (startTx && mode == `USP_MODE0)
                begin
                    d.txSt = TX_SHIFT;
                    d.txSh = {2'b00, pwdata[7:0]};
                    d.txBits = `USP_DATA_BITS;
                    d.rxdOut = pwdata[0];
                    d.rxdOeN = 1'b0;
                end
                else if (startTx)
                begin
                    d.txSt = TX_UART;
                    d.txLine = 1'b0;
                    d.txSub = 4'd0;
                    d.txSh = {1'b1, (mode == `USP_MODE1) ? 1'b1
                              : q.scon[`USP_CTRL_TB8], pwdata[7:0]};
                    d.txBits = (mode == `USP_MODE1) ? `USP_M1_TAIL
                                                    : `USP_M9_TAIL;
                end
            end
            TX_UART:
            begin
                if (tick)
                begin
                    d.txSub = q.txSub + 4'd1;
                    if (q.txSub == `USP_SUB_LAST)
                    begin
                        if (q.txBits == 4'd0)
                            d.txSt = TX_IDLE;
                        else
                        begin
                            d.txLine = q.txSh[0];
                            d.txSh = {1'b1, q.txSh[9:1]};
                            d.txBits = q.txBits - 4'd1;
                            if (q.txBits == 4'd1)
                                ev[`USP_IRQ_TX] = 1'b1;
                        end
                    end
                end
            end
            TX_SHIFT:
            begin
                if (m0Half)
                begin
                    d.m0Clk = ~q.m0Clk;
                    // The rising clock edge closes a bit time.
                    if (!q.m0Clk)
                    begin
                        d.txSh = {1'b0, q.txSh[9:1]};
                        d.rxdOut = q.txSh[1];
                        d.txBits = q.txBits - 4'd1;
                        if (q.txBits == 4'd1)
                        begin
                            ev[`USP_IRQ_TX] = 1'b1;
                            d.txSt = TX_IDLE;
                            d.rxdOeN = 1'b1;
                            d.rxdOut = 1'b1;
                        end
                    end
                end
            end
        endcase

        // The edge detector reads the synchroniser output only.
        d.rxPrev = rxdSync;
        unique case (q.rxSt)
            RX_IDLE:
            begin
                if (ren && mode == `USP_MODE0)
                begin
                    if (!q.scon[`USP_CTRL_RI] && q.txSt == TX_IDLE && !startTx)
                    begin
                        d.rxSt = RX_SHIFT;
                        d.rxBits = 4'd0;
                    end
                end
                else if (ren && q.rxPrev && !rxdSync)
                begin
                    d.rxSt = RX_START;
                    d.rxSub = 4'd0;
                end
            end
            RX_START:
            begin
                if (!ren)
                    d.rxSt = RX_IDLE;
                else if (tick)
                begin
                    d.rxSub = q.rxSub + 4'd1;
                    // A start bit that is high again at mid-bit was a glitch.
                    if (q.rxSub == `USP_SUB_MID)
                    begin
                        d.rxSub = 4'd0;
                        d.rxBits = 4'd0;
                        d.rxSt = rxdSync ? RX_IDLE : RX_DATA;
                    end
                end
            end
            RX_DATA:
            begin
                if (!ren)
                    d.rxSt = RX_IDLE;
                else if (tick)
                begin
                    d.rxSub = q.rxSub + 4'd1;
                    if (q.rxSub == `USP_SUB_LAST)
                    begin
                        d.rxBits = q.rxBits + 4'd1;
                        if (q.rxBits < `USP_DATA_BITS)
                            d.rxSh = {rxdSync, q.rxSh[7:1]};
                        else if (q.rxBits == `USP_DATA_BITS
                                 && mode != `USP_MODE1)
                            d.rxNinth = rxdSync;
                        else
                        begin
                            d.rxSt = RX_IDLE;
                            if (!rxdSync)
                            begin
                                d.fe = 1'b1;
                                ev[`USP_IRQ_FE] = 1'b1;
                            end
                            accept = ~q.scon[`USP_CTRL_RI] & (~sm2
                                     | ((mode == `USP_MODE1) ? rxdSync
                                                            : q.rxNinth));
                            if (accept)
                            begin
                                d.rxBuf = q.rxSh;
                                d.scon[`USP_CTRL_RB8] = (mode == `USP_MODE1)
                                    ? rxdSync : q.rxNinth;
                                ev[`USP_IRQ_RX] = 1'b1;
                            end
                        end
                    end
                end
            end
            RX_SHIFT:
            begin
                if (!ren)
                begin
                    d.rxSt = RX_IDLE;
                    d.m0Clk = 1'b1;
                end
                else if (m0Half)
                begin
                    d.m0Clk = ~q.m0Clk;
                    if (!q.m0Clk)
                    begin
                        d.rxSh = {rxdSync, q.rxSh[7:1]};
                        d.rxBits = q.rxBits + 4'd1;
                        if (q.rxBits == `USP_M0_LAST)
                        begin
                            d.rxSt = RX_IDLE;
                            d.rxBuf = {rxdSync, q.rxSh[7:1]};
                            ev[`USP_IRQ_RX] = 1'b1;
                        end
                    end
                end
            end
        endcase

        // Hardware sets win over a software clear in the same cycle.
        if (ev[`USP_IRQ_TX])
            d.scon[`USP_CTRL_TI] = 1'b1;
        if (ev[`USP_IRQ_RX])
            d.scon[`USP_CTRL_RI] = 1'b1;
        d.irqSt = d.irqSt | ev;
        d.txd = ({d.scon[`USP_CTRL_SM0], d.scon[`USP_CTRL_SM1]} == `USP_MODE0)
                ? d.m0Clk : d.txLine;

        if (setup)
        begin
            d.slvErr = ~isMapped(paddr);
            case (paddr)
                `USP_OFF_CTRL:     d.rdata = {24'h0, view};
                `USP_OFF_BUF:      d.rdata = {24'h0, q.rxBuf};
                `USP_OFF_BAUD:     d.rdata = {26'h0, q.bcon};
                `USP_OFF_RELOAD:   d.rdata = {24'h0, q.reload};
                `USP_OFF_IRQ_ST:   d.rdata = {29'h0, q.irqSt};
                `USP_OFF_IRQ_MASK: d.rdata = {29'h0, q.irqMask};
                default:           d.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            q <= RST_STATE;
        else
            q <= d;
    end

    assign prdata  = q.rdata;
    assign pready  = 1'b1;
    assign pslverr = q.slvErr & psel & penable;
    assign txd     = q.txd;
    assign rxdOut  = q.rxdOut;
    assign rxdOeN  = q.rxdOeN;
    assign irq     = |(q.irqSt & q.irqMask);
endmodule : usp_top

// ---- shared/usp_defs.svh ----
/*
 * Constants of the serial port: register offsets, bit positions,
 * reset values, mode codes and bit-timing counts.
 * Assumes inclusion by its bare name from the design files.
 */
// Contract
// - Framing error flag set on a bad stop bit; only a zero write clears it.
// - Control bit 7 shows framing error when select is set, else mode bit.
// - Modes: 00 shift /6, 01 8-bit, 10 9-bit /32 or /16, 11 9-bit.
// - Multiprocessor enable filters frames in modes 2, 3 and 1; not mode 0.
// - Reception happens only while the reception enable bit is set.
// - Modes 2 and 3 send the transmit ninth bit as ninth data bit.
// - Modes 2 and 3 load the received ninth bit into its field.
// - Mode 1 without multiprocessor stores the stop bit; unused in mode 0.
// - Transmit flag sets after bit 8 in mode 0, else at stop start.
// - Mode 0 receive flag sets after bit 8 and stays until cleared.
// - Control register resets to zero and allows single bit access.
// - Internal generator clocks modes 1 and 3, and mode 0 if selected.
// - Double rate bit doubles baud in modes 1, 2, 3; mode 2 uses /16.
// - Generator: 8-bit reload counter, scaled by speed /6, double, 32.
`ifndef USP_DEFS_SVH
`define USP_DEFS_SVH

`define USP_OFF_CTRL      8'h00
`define USP_OFF_BUF       8'h04
`define USP_OFF_BAUD      8'h08
`define USP_OFF_RELOAD    8'h0c
`define USP_OFF_IRQ_ST    8'h10
`define USP_OFF_IRQ_MASK  8'h14
`define USP_OFF_CTRL_SET  8'h18
`define USP_OFF_CTRL_CLR  8'h1c

`define USP_CTRL_SM0      7
`define USP_CTRL_SM1      6
`define USP_CTRL_SM2      5
`define USP_CTRL_REN      4
`define USP_CTRL_TB8      3
`define USP_CTRL_RB8      2
`define USP_CTRL_TI       1
`define USP_CTRL_RI       0

`define USP_BAUD_SRC      0
`define USP_BAUD_SPD      1
`define USP_BAUD_SEL      2
`define USP_BAUD_RUN      3
`define USP_BAUD_DBL      4
`define USP_BAUD_FES      5

`define USP_IRQ_TX        0
`define USP_IRQ_RX        1
`define USP_IRQ_FE        2

`define USP_CTRL_RST      8'h00
`define USP_BAUD_RST      6'h00
`define USP_RELOAD_RST    8'h00
`define USP_IRQ_RST       3'h0

`define USP_MODE0         2'b00
`define USP_MODE1         2'b01
`define USP_MODE2         2'b10

`define USP_M0_HALF_DIV   2'd2
`define USP_PRE_LAST      3'd5
`define USP_CNT_TOP       8'hff
`define USP_SUB_LAST      4'd15
`define USP_SUB_MID       4'd7
`define USP_DATA_BITS     4'd8
`define USP_M0_LAST       4'd7
`define USP_M1_TAIL       4'd9
`define USP_M9_TAIL       4'd10

`endif

// ---- shared/usp_pkg.sv ----
/*
 * Types of the serial port: state enumerations and the state records.
 * Assumes nothing of its surroundings.
 */
package usp_pkg;

    typedef enum logic [1:0] {TX_IDLE, TX_UART, TX_SHIFT} usp_tx_e;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_SHIFT} usp_rx_e;

    typedef struct packed {
        logic [7:0]  scon;
        logic        fe;
        logic [5:0]  bcon;
        logic [7:0]  reload;
        logic [2:0]  irqSt;
        logic [2:0]  irqMask;
        logic [7:0]  rxBuf;
        logic [31:0] rdata;
        logic        slvErr;
        logic [1:0]  divCnt;
        logic        ovfHalf;
        logic        m2Tog;
        usp_tx_e     txSt;
        logic [9:0]  txSh;
        logic [3:0]  txBits;
        logic [3:0]  txSub;
        logic        txLine;
        logic        m0Clk;
        logic        txd;
        logic        rxdOut;
        logic        rxdOeN;
        usp_rx_e     rxSt;
        logic [7:0]  rxSh;
        logic        rxNinth;
        logic [3:0]  rxBits;
        logic [3:0]  rxSub;
        logic        rxPrev;
    } usp_state_s;

    typedef struct packed {
        logic [2:0] pre;
        logic [7:0] cnt;
        logic       ovf;
    } usp_brg_s;

endpackage : usp_pkg

// ---- shared/usp_brg_if.sv ----
/*
 * Link between the serial core and its internal baud generator.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface usp_brg_if;
    logic [7:0] reload;
    logic       speed;
    logic       run;
    logic       ovf;

    modport gen  (input reload, input speed, input run, output ovf);
    modport user (output reload, output speed, output run, input ovf);
endinterface : usp_brg_if

// ---- hw/usp_sync.sv ----
/*
 * Two-stage synchroniser for the serial receive pin.
 * Assumes the pin idles high, so both stages reset high.
 */
`timescale 1ns/1ps
module usp_sync
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic [1:0] q;
    logic [1:0] d;

    always_comb
    begin
        d = {q[0], din};
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            q <= 2'h3;
        else
            q <= d;
    end

    assign dout = q[1];
endmodule : usp_sync

// ---- hw/usp_brg.sv ----
/*
 * Internal baud generator: optional divide by six, then an 8-bit
 * counter that reloads on overflow and emits a one-cycle pulse.
 * Assumes the reload value and controls come over the interface.
 */
`timescale 1ns/1ps
`include "usp_defs.svh"
module usp_brg
    import usp_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    usp_brg_if.gen    bus
);
    usp_brg_s q;
    usp_brg_s d;
    logic     step;

    always_comb
    begin
        d = q;
        d.ovf = 1'b0;
        step = bus.speed | (q.pre == `USP_PRE_LAST);
        if (!bus.run)
        begin
            d.pre = 3'd0;
            d.cnt = bus.reload;
        end
        else
        begin
            d.pre = step ? 3'd0 : q.pre + 3'd1;
            if (step)
            begin
                if (q.cnt == `USP_CNT_TOP)
                begin
                    d.cnt = bus.reload;
                    d.ovf = 1'b1;
                end
                else
                    d.cnt = q.cnt + 8'd1;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            q <= '{pre: 3'd0, cnt: `USP_RELOAD_RST, ovf: 1'b0};
        else
            q <= d;
    end

    assign bus.ovf = q.ovf;
endmodule : usp_brg

// ---- tb/usp_top_assertions.sv ----
/* Checker for the serial port top: bus answers, pin levels and bit timing.
   Assumes mode and rate are set by plain writes to the control and baud
   words, which it shadows. */
`timescale 1ns/1ps
`include "usp_defs.svh"
module usp_top_assertions
(
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    input wire logic        txd,
    input wire logic        rxdOut,
    input wire logic        rxdOeN,
    input wire logic        irq
);
    logic [1:0] modeQ;
    logic       fesQ;
    logic       dblQ;
    logic [5:0] oeCntQ;
    logic       wrEn;

    assign wrEn = psel && penable && pwrite;

    // Writes through the bit-set and bit-clear words are not shadowed.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            modeQ  <= 2'h0;
            fesQ   <= 1'b0;
            dblQ   <= 1'b0;
            oeCntQ <= 6'h0;
        end
        else
        begin
            if (wrEn && paddr == `USP_OFF_CTRL)
                modeQ <= {fesQ ? modeQ[1] : pwdata[7], pwdata[6]};
            if (wrEn && paddr == `USP_OFF_BAUD)
                {fesQ, dblQ} <= pwdata[5:4];
            oeCntQ <= rxdOeN ? 6'h0 : oeCntQ + 6'h1;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_low8;
        !txd [*8];
    endsequence

    property p_reset_idle;
        $rose(rst_n) |-> txd && rxdOut && rxdOeN && !irq;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("pins not idle after reset");

    property p_unmapped;
        psel && penable && (paddr[1:0] != 2'h0 || paddr > 8'h1c) |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");

    property p_err_access;
        !(psel && penable) |-> !pslverr;
    endproperty
    a_err_access: assert property (p_err_access)
        else $error("error outside access phase");

    property p_oe_mode0;
        !rxdOeN |-> modeQ == `USP_MODE0;
    endproperty
    a_oe_mode0: assert property (p_oe_mode0)
        else $error("data pin driven outside shift mode");

    property p_m0_half;
        !rxdOeN && $fell(txd) |-> !txd [*3] ##1 txd;
    endproperty
    a_m0_half: assert property (p_m0_half)
        else $error("shift clock half period wrong");

    property p_m0_len;
        $rose(rxdOeN) |-> oeCntQ >= 6'd44 && oeCntQ <= 6'd48;
    endproperty
    a_m0_len: assert property (p_m0_len)
        else $error("shift transfer length wrong");

    property p_m2_start;
        wrEn && paddr == `USP_OFF_BUF && modeQ == `USP_MODE2 && dblQ
            |=> ##1 s_low8 ##1 !txd [*7];
    endproperty
    a_m2_start: assert property (p_m2_start)
        else $error("start bit shorter than sixteen clocks");

    property p_irq_mask;
        wrEn && paddr == `USP_OFF_IRQ_MASK && pwdata[2:0] == 3'h0 |=> !irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt high with all sources masked");
endmodule : usp_top_assertions

bind usp_top usp_top_assertions u_chk
(
    .core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pslverr(pslverr), .txd(txd), .rxdOut(rxdOut), .rxdOeN(rxdOeN),
    .irq(irq)
);

// ---- tb/usp_remote.sv ----
/* Remote serial node: sends frames on the receive pin and captures
   frames from the transmit pin, least significant bit first.
   Assumes the caller gives the bit length in core clock cycles. */
`timescale 1ns/1ps
module usp_remote
(
    input  wire logic core_clk,
    input  wire logic txd,
    output logic      rxdIn
);
    // The line rests at the mark level between frames, as a UART line does.
    initial rxdIn = 1'b1;

    task automatic send(input logic [8:0] d, input int nBits,
                        input logic stopBit, input int cpb);
        rxdIn <= 1'b0;
        repeat (cpb) @(posedge core_clk);
        for (int i = 0; i < nBits; i++)
        begin
            rxdIn <= d[i];
            repeat (cpb) @(posedge core_clk);
        end
        rxdIn <= stopBit;
        repeat (cpb) @(posedge core_clk);
        rxdIn <= 1'b1;
    endtask : send

    // Samples mid-bit, so a clock off by one count drifts out of the bit.
    task automatic recv(output logic [8:0] d, input int nBits, input int cpb);
        d = 9'h000;
        @(negedge txd);
        repeat (cpb / 2) @(posedge core_clk);
        for (int i = 0; i < nBits; i++)
        begin
            repeat (cpb) @(posedge core_clk);
            d[i] = txd;
        end
    endtask : recv
endmodule : usp_remote

// ---- tb/usp_top_test.sv ----
/* Self-checking bench for the serial port: registers over APB, frames in
   modes 0, 1 and 2, flags and the interrupt line. Assumes the remote
   node model and the bound checker. */
`timescale 1ns/1ps
module usp_top_test;
    logic        core_clk, rst_n, timerOvf, txd, rxdIn, rxdOut, rxdOeN, irq;
    logic        psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [8:0]  fr;
    int          n_fail = 0;
    int          check_count = 0;
    int          cycles = 0;

    usp_top DUT
    (
        .core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timerOvf(timerOvf), .txd(txd), .rxdIn(rxdIn), .rxdOut(rxdOut),
        .rxdOeN(rxdOeN), .irq(irq)
    );
    usp_remote PEER (.core_clk(core_clk), .txd(txd), .rxdIn(rxdIn));

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_fail++;
            results();
        end
    end

    task automatic results;
        if (n_fail == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        rv = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rv & m, e);
    endtask : rd

    task automatic t_reset;
        rd(8'h00, '1, 32'h0);
        rd(8'h08, '1, 32'h0);
        rd(8'h10, '1, 32'h0);
        rd(8'h22, '1, 32'h0);
        chk({31'h0, er}, 32'h1);
        wr(8'h18, 32'h48);
        wr(8'h1c, 32'h40);
        rd(8'h00, '1, 32'h08);
    endtask : t_reset

    task automatic t_mode2_tx;
        wr(8'h14, 32'h1);
        for (int b = 0; b < 2; b++)
        begin
            wr(8'h08, 32'(b * 16));
            wr(8'h00, 32'(128 + b * 8));
            wr(8'h04, 32'ha5);
            PEER.recv(fr, 9, 32 - b * 16);
            chk({23'h0, fr}, 32'(165 + b * 256));
            rd(8'h00, '1, 32'(128 + b * 8));
            repeat (16) @(posedge core_clk);
            rd(8'h00, '1, 32'(130 + b * 8));
            repeat (32) @(posedge core_clk);
        end
        chk({31'h0, irq}, 32'h1);
        wr(8'h14, 32'h0);
        @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        wr(8'h14, 32'h1);
        wr(8'h10, 32'h1);
        @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
    endtask : t_mode2_tx

    task automatic t_mode2_rx;
        wr(8'h00, 32'hb0);
        PEER.send(9'h03c, 9, 1'b1, 16);
        rd(8'h00, '1, 32'hb0);
        PEER.send(9'h13c, 9, 1'b1, 16);
        rd(8'h00, '1, 32'hb5);
        wr(8'h00, 32'h90);
        PEER.send(9'h0c3, 9, 1'b1, 16);
        rd(8'h00, '1, 32'h91);
        rd(8'h04, '1, 32'hc3);
        wr(8'h08, 32'h30);
        rd(8'h00, 32'h80, 32'h0);
        PEER.send(9'h0aa, 9, 1'b0, 16);
        rd(8'h00, 32'h80, 32'h80);
        rd(8'h10, 32'h4, 32'h4);
        PEER.send(9'h0aa, 9, 1'b1, 16);
        rd(8'h00, 32'h80, 32'h80);
        wr(8'h00, 32'h10);
        rd(8'h00, 32'h80, 32'h0);
        wr(8'h08, 32'h10);
        rd(8'h00, 32'h80, 32'h80);
    endtask : t_mode2_rx

    task automatic t_ren_off;
        wr(8'h00, 32'h80);
        PEER.send(9'h155, 9, 1'b1, 16);
        rd(8'h00, '1, 32'h80);
    endtask : t_ren_off

    task automatic t_mode1;
        wr(8'h0c, 32'hf0);
        wr(8'h08, 32'h1e);
        wr(8'h00, 32'h50);
        PEER.send(9'h05a, 8, 1'b1, 256);
        rd(8'h00, '1, 32'h55);
        rd(8'h04, '1, 32'h5a);
        wr(8'h00, 32'hc8);
        wr(8'h04, 32'hc3);
        PEER.recv(fr, 9, 256);
        chk({23'h0, fr}, 32'h1c3);
        repeat (512) @(posedge core_clk);
    endtask : t_mode1

    task automatic t_mode0;
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h96);
        for (int i = 0; i < 8; i++)
            @(negedge txd) fr[i] = rxdOut;
        chk({24'h0, fr[7:0]}, 32'h96);
        repeat (4) @(posedge core_clk);
        chk({31'h0, rxdOeN}, 32'h1);
        rd(8'h00, '1, 32'h02);
        wr(8'h00, 32'h10);
        repeat (60) @(posedge core_clk);
        rd(8'h00, '1, 32'h11);
        rd(8'h04, '1, 32'hff);
        wr(8'h00, 32'h0);
    endtask : t_mode0

    initial
    begin
        rst_n    = 1'b0;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 8'h0;
        pwdata   = 32'h0;
        timerOvf = 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_mode2_tx();
        t_mode2_rx();
        t_ren_off();
        t_mode1();
        t_mode0();
        results();
    end
endmodule : usp_top_test
